// ---- dpc_decoder.sv ----
// dpc_decoder: serial command decoder for two 64-tap wipers and their stored settings
`timescale 1ns/10ps
module dpc_decoder
    import dpc_pkg::*;
#(
    parameter int P_NVW_CYC = NVW_CYC,       // write cycle length, shortened in simulation
    parameter logic [3:0] P_DEV_TYPE = 4'hA  // device type nibble, value arbitrary
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic [1:0] i_strap_addr,
    output logic o_so,
    output logic o_so_oe,
    output logic [5:0] o_wiper0,
    output logic [5:0] o_wiper1,
    output logic o_write_in_progress
);
    // edge counter, cleared whenever the frame is closed
    typedef struct packed {
        logic [4:0] cnt;
        logic [7:0] sh;
    } dpc_cnt_t;
    // frame record, kept past the end of the frame for the core to read
    typedef struct packed {
        logic addr_ok;
        logic [7:0] instr;
        logic [7:0] data;
        logic [4:0] nbits;
        logic up_tog;
        logic dn_tog;
    } dpc_rec_t;
    // core state on the reference clock
    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] up_s;
        logic [2:0] dn_s;
        logic [1:0][1:0] strap_s;
        logic [1:0][5:0] wiper;
        logic [1:0][3:0][5:0] stored;
        logic [1:0][5:0] wout;
        logic write_in_progress_flag;
        logic [16:0] nv_cnt;
        logic [1:0][5:0] snap_wiper;
        logic [1:0][3:0][5:0] snap_stored;
        logic snap_wip;
        logic [1:0] snap_strap;
    } dpc_core_t;

    dpc_cnt_t c_q, c_d;  // link counter
    dpc_rec_t r_q, r_d;  // link record
    dpc_core_t q, d;     // core

    logic [7:0] in_byte;    // byte completed at this edge
    logic [3:0] op;         // decoded opcode of the record
    logic [1:0] slot;       // slot select high and low
    logic pot;              // pot select bit
    logic step_en;          // step mode armed in this frame
    logic rd_cmd;           // a read-type instruction is active
    logic [7:0] rd_byte;    // byte shifted out in the data phase
    logic [2:0] bit_idx;    // data phase bit position
    logic cs_rise;          // end of frame seen in the core
    logic up_evt;           // one step up arrived
    logic dn_evt;           // one step down arrived
    logic nv_start;         // a nonvolatile write begins
    logic ex_wwr;           // write wiper executes
    logic ex_recall;        // single recall executes
    logic frame_ok;         // instruction well formed
    logic so_q; // serial out bit, launched on the falling edge
    logic so_oe_q; // serial out drive enable, launched with the bit

    // record decode; stable once the instruction byte is in
    always_comb begin
        op = r_q.instr[OP_MSB:OP_LSB];
        slot = r_q.instr[SLOT_MSB:SLOT_LSB];
        pot = r_q.instr[POT_BIT];
        frame_ok = r_q.addr_ok && !r_q.instr[ZERO_BIT];
        step_en = frame_ok && op == OP_STEP && slot == 2'h0 && c_q.cnt >= LEN_SHORT;
        rd_cmd = frame_ok && c_q.cnt >= LEN_SHORT && c_q.cnt < LEN_LONG
            && ((op == OP_RD_WIPER && slot == 2'h0) || op == OP_RD_STORED
            || (op == OP_STATUS && slot == 2'h0 && pot));
    end

    // serial edge counter; reset held while select is high
    always_comb begin
        c_d = c_q;
        in_byte = {c_q.sh[6:0], i_si};
        // msb first, sampled on rising edge
        c_d.sh = in_byte;
        if (c_q.cnt != CNT_MAX) begin
            c_d.cnt = c_q.cnt + 5'h01;
        end
    end

    // select high forces a constant, so the counter starts clean each frame
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    // record update; not cleared by select so the core can read it after the frame
    always_comb begin
        r_d = r_q;
        r_d.nbits = c_d.cnt;
        // strap address compare, other low bits zero
        if (c_q.cnt == BITS_ADDR) begin
            r_d.addr_ok = in_byte == {P_DEV_TYPE, 2'b00, q.snap_strap};
        end
        if (c_q.cnt == BITS_INSTR) begin
            r_d.instr = in_byte;
        end
        if (c_q.cnt == BITS_DATA) begin
            r_d.data = in_byte;
        end
        // high input steps toward high terminal
        if (step_en && i_si) begin
            r_d.up_tog = !r_q.up_tog;
        end
        // low input steps toward low terminal
        if (step_en && !i_si) begin
            r_d.dn_tog = !r_q.dn_tog;
        end
    end

    // toggles must never reset with select, or the core would see a false step
    always_ff @(posedge i_sck or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // read data from the frozen snapshot; core does not touch it mid frame
    always_comb begin
        unique case (op)
            OP_RD_WIPER: rd_byte = {2'b00, q.snap_wiper[pot]};
            OP_RD_STORED: rd_byte = {2'b00, q.snap_stored[pot][slot]};
            default: rd_byte = {7'h00, q.snap_wip};
        endcase
        bit_idx = 3'h7 - c_q.cnt[2:0];
    end

    // output moves on the falling edge, so it stands across the next rising edge
    // select high disables the output at once, even with the serial clock parked
    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else begin
            so_q <= rd_cmd ? rd_byte[bit_idx] : 1'b0;
            so_oe_q <= rd_cmd;
        end
    end

    // data output straight from its flip-flops
    assign o_so = so_q;
    assign o_so_oe = so_oe_q;

    // core next state
    always_comb begin
        d = q;
        // synchronisers; only the second and third stages are looked at
        d.cs_s = {q.cs_s[1:0], i_cs_n};
        d.up_s = {q.up_s[1:0], r_q.up_tog};
        d.dn_s = {q.dn_s[1:0], r_q.dn_tog};
        d.strap_s = {q.strap_s[0], i_strap_addr};
        cs_rise = q.cs_s[1] && !q.cs_s[2];
        up_evt = q.up_s[1] != q.up_s[2];
        dn_evt = q.dn_s[1] != q.dn_s[2];
        nv_start = 1'b0;
        ex_wwr = 1'b0;
        ex_recall = 1'b0;
        // snapshot follows while idle, freezes during a frame
        if (q.cs_s[1]) begin
            d.snap_wiper = q.wiper;
            d.snap_stored = q.stored;
            d.snap_wip = q.write_in_progress_flag;
            d.snap_strap = q.strap_s[1];
        end
        // any mix of steps until select rises
        if (up_evt && q.wiper[pot] != TAP_MAX) begin
            d.wiper[pot] = q.wiper[pot] + 6'h01;
        end
        if (dn_evt && q.wiper[pot] != TAP_MIN) begin
            d.wiper[pot] = q.wiper[pot] - 6'h01;
        end
        // three-byte instructions need exactly 24 edges
        if (cs_rise && frame_ok && r_q.nbits == LEN_LONG) begin
            if (op == OP_WR_WIPER && slot == 2'h0 && r_q.data[7:6] == 2'b00) begin
                d.wiper[pot] = r_q.data[5:0];
                ex_wwr = 1'b1;
            end
            // write stored setting; refused while a write runs
            if (op == OP_WR_STORED && !q.write_in_progress_flag) begin
                d.stored[pot][slot] = r_q.data[5:0];
                nv_start = 1'b1;
            end
        end
        if (cs_rise && frame_ok && r_q.nbits == LEN_SHORT) begin
            if (op == OP_RECALL) begin
                d.wiper[pot] = q.stored[pot][slot];
                ex_recall = 1'b1;
            end
            if (op == OP_SAVE && !q.write_in_progress_flag) begin
                d.stored[pot][slot] = q.wiper[pot];
                nv_start = 1'b1;
            end
            if (op == OP_GRECALL && !pot) begin
                d.wiper[0] = q.stored[0][slot];
                d.wiper[1] = q.stored[1][slot];
            end
            if (op == OP_GSAVE && !pot && !q.write_in_progress_flag) begin
                d.stored[0][slot] = q.wiper[0];
                d.stored[1][slot] = q.wiper[1];
                nv_start = 1'b1;
            end
        end
        // write cycle begins only at frame end
        if (nv_start) begin
            d.write_in_progress_flag = 1'b1;
            d.nv_cnt = '0;
        end else if (q.write_in_progress_flag) begin
            // flag held for the whole write time
            if (q.nv_cnt == 17'(P_NVW_CYC - 1)) begin
                d.write_in_progress_flag = 1'b0;
            end else begin
                d.nv_cnt = q.nv_cnt + 17'h00001;
            end
        end
        // tap selection follows one cycle after a load
        d.wout = q.wiper;
    end

    // core register
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            q <= '0;
            q.cs_s <= 3'h7;
            q.wiper <= {2{WIPER_RST}};
            q.stored <= {8{STORED_RST}};
            q.wout <= {2{WIPER_RST}};
            q.snap_wiper <= {2{WIPER_RST}};
            q.snap_stored <= {8{STORED_RST}};
        end else begin
            q <= d;
        end
    end

    assign o_write_in_progress = q.write_in_progress_flag;
    assign o_wiper0 = q.wout[0];
    assign o_wiper1 = q.wout[1];

    localparam int A_SETTLE = SETTLE_CYC;

    a_wip_start: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        $rose(q.write_in_progress_flag) |-> $past(cs_rise)) else $error("write flag rose without frame end");
    a_wip_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        q.write_in_progress_flag && q.nv_cnt < 17'(P_NVW_CYC - 1) |=> q.write_in_progress_flag)
        else $error("write flag dropped early");
    a_wip_end: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        q.write_in_progress_flag && q.nv_cnt == 17'(P_NVW_CYC - 1) && !nv_start |=> !o_write_in_progress)
        else $error("write flag did not clear");
    a_wiper_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        ex_wwr |=> q.wiper[$past(pot)] == $past(r_q.data[5:0]))
        else $error("wiper write lost");
    a_recall_load: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        ex_recall |=> q.wiper[$past(pot)] == $past(q.stored[pot][slot]))
        else $error("recall value wrong");
    a_step_up: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        up_evt && !dn_evt && q.wiper[pot] != TAP_MAX && !cs_rise
        |=> q.wiper[$past(pot)] == $past(q.wiper[pot]) + 6'h01)
        else $error("step up missed");
    a_step_floor: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        dn_evt && !up_evt && !cs_rise && q.wiper[pot] == TAP_MIN
        |=> q.wiper[$past(pot)] == TAP_MIN) else $error("step wrapped below floor");
    a_out_settle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        $changed(q.wiper[0]) |-> ##[1:A_SETTLE] o_wiper0 == q.wiper[0])
        else $error("wiper output not settled");
    a_read_top: assert property (@(posedge i_sck) disable iff (i_cs_n)
        o_so_oe && c_q.cnt < 5'h12 |-> !o_so) else $error("read byte top bits not zero");
endmodule // dpc_decoder

// ---- dpc_pkg.sv ----
// dpc_pkg: constants shared by the dual pot serial command decoder
package dpc_pkg;
    // frame lengths in serial clock edges
    localparam logic [4:0] BITS_ADDR = 5'h07;   // last edge index of address byte
    localparam logic [4:0] BITS_INSTR = 5'h0F;  // last edge index of instruction byte
    localparam logic [4:0] BITS_DATA = 5'h17;   // last edge index of data byte
    localparam logic [4:0] LEN_SHORT = 5'h10;   // two-byte frame
    localparam logic [4:0] LEN_LONG = 5'h18;    // three-byte frame
    localparam logic [4:0] CNT_MAX = 5'h1F;     // saturation of the edge counter
    // instruction byte fields
    localparam int OP_MSB = 7;
    localparam int OP_LSB = 4;
    localparam int SLOT_MSB = 3;
    localparam int SLOT_LSB = 2;
    localparam int ZERO_BIT = 1;
    localparam int POT_BIT = 0;
    // opcodes
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_STORED = 4'hB;
    localparam logic [3:0] OP_WR_STORED = 4'hC;
    localparam logic [3:0] OP_RECALL = 4'hD;
    localparam logic [3:0] OP_SAVE = 4'hE;
    localparam logic [3:0] OP_GRECALL = 4'h1;
    localparam logic [3:0] OP_GSAVE = 4'h8;
    localparam logic [3:0] OP_STEP = 4'h2;
    localparam logic [3:0] OP_STATUS = 4'h5;
    // wiper range
    localparam logic [5:0] TAP_MAX = 6'h3F;
    localparam logic [5:0] TAP_MIN = 6'h00;
    localparam logic [5:0] WIPER_RST = 6'h00;
    localparam logic [5:0] STORED_RST = 6'h00;
    // timing
    localparam int CLK_MHZ = 25;
    localparam int CLK_NS = 40;
    localparam int NVW_TIME_US = 5000;           // nonvolatile write time, longest
    localparam int NVW_CYC = NVW_TIME_US * CLK_MHZ;
    localparam int SETTLE_TIME_NS = 10000;       // wiper settle delay, longest
    localparam int SETTLE_CYC = SETTLE_TIME_NS / CLK_NS;
endpackage : dpc_pkg

// ---- dpc_spi_master.sv ----
// dpc_spi_master: behavioural serial master model for the decoder link pins
`timescale 1ns/10ps
module dpc_spi_master (
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si
);
    logic base_clk; // link base clock, 30 ns, free of the core clock phase
    initial begin
        base_clk = 1'b0;
        forever #15 base_clk = ~base_clk;
    end
    // idle: select high, serial clock parked low
    initial begin
        o_sck <= 1'b0;
        o_cs_n <= 1'b1;
        o_si <= 1'b0;
    end
    // wait a number of base clock edges
    task automatic gap(input int n);
        repeat (n) @(posedge base_clk);
    endtask
    // msb first, mode 0, clock still between frames
    task automatic frame(input logic [31:0] bits, input int n, output logic [7:0] rd);
        rd = 8'h00;
        gap(1);
        o_cs_n <= 1'b0;
        gap(9);
        // half periods of 180 ns keep step edges over 333 ns apart
        for (int k = 0; k < n; k++) begin
            o_si <= bits[n - 1 - k];
            gap(6);
            // read bits taken at the rising edge, as a mode 0 master does
            // an undriven output reads as unknown, so it can never match
            if (k >= 16 && k <= 23) rd[23 - k] = (i_so_oe === 1'b1) ? i_so : 1'bX;
            o_sck <= 1'b1;
            gap(6);
            o_sck <= 1'b0;
        end
        gap(9);
        o_cs_n <= 1'b1;
        o_si <= ~o_si;
        gap(20);
    endtask
endmodule // dpc_spi_master

// ---- tb_top.sv ----
// tb_top: self-checking bench for the dual pot serial command decoder
`timescale 1ns/10ps
module tb_top;
    import dpc_pkg::*;
    typedef struct {
        logic [7:0] ins; // instruction byte
        logic [7:0] dat; // data byte
        int n; // edges in the frame
        logic [1:0] sa; // strap field sent
        logic ck; // compare the read byte
        logic [7:0] rd; // expected read byte
        logic [5:0] w0; // expected wiper 0
        logic [5:0] w1; // expected wiper 1
    } dpc_row_t;
    localparam int NVW = 400; // shortened write cycle
    localparam logic [3:0] DEV = 4'hA; // device type, value arbitrary
    localparam logic [1:0] SA = 2'h2; // strap pins
    logic i_ref_clk, i_sys_rst, o_so, o_so_oe, o_write_in_progress, sck, cs_n, si;
    logic [1:0] i_strap_addr;
    logic [5:0] o_wiper0, o_wiper1;
    logic [7:0] rd;
    int miscompares, checks;
    dpc_row_t rows[25];
    dpc_decoder #(.P_NVW_CYC(NVW), .P_DEV_TYPE(DEV)) dut (.i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
        .i_strap_addr(i_strap_addr), .o_so(o_so), .o_so_oe(o_so_oe), .o_wiper0(o_wiper0),
        .o_wiper1(o_wiper1), .o_write_in_progress(o_write_in_progress));
    dpc_spi_master mst (.i_so(o_so), .i_so_oe(o_so_oe), .o_sck(sck), .o_cs_n(cs_n), .o_si(si));
    // core clock, 40 ns
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    // verdict and end of run
    task automatic report_and_stop();
        if (miscompares == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // compare tasks, one per result kind
    task automatic cmp6(input string nm, input logic [5:0] e, input logic [5:0] s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one frame; short frames carry no data byte, edges past the data byte send zeros
    task automatic send(input logic [7:0] ins, input logic [7:0] dat, input int n,
                        input logic [1:0] sa);
        logic [7:0] adr;
        adr = {DEV, 2'b00, sa};
        mst.frame({adr, ins, dat, 8'h00} >> (32 - n), n, rd);
    endtask
    // bounded wait for the write cycle to finish, then let wipers land
    task automatic settle();
        for (int i = 0; i < 1000 && o_write_in_progress !== 1'b0; i++) @(posedge i_ref_clk);
        cmp8("flag settled", 8'h00, {7'h00, o_write_in_progress});
        repeat (6) @(posedge i_ref_clk);
    endtask
    // watchdog, about four times the expected run
    initial begin
        #1500us;
        miscompares++;
        report_and_stop();
    end
    initial begin
        rows = '{
            '{8'hA0, 8'h2A, 24, SA, 0, 0, 6'h2A, 6'h00}, '{8'hA1, 8'h15, 24, SA, 0, 0, 6'h2A, 6'h15},
            '{8'hA1, 8'h55, 24, SA, 0, 0, 6'h2A, 6'h15}, '{8'h90, 8'h00, 24, SA, 1, 8'h2A, 6'h2A, 6'h15},
            '{8'h91, 8'h00, 24, SA, 1, 8'h15, 6'h2A, 6'h15}, '{8'hC8, 8'h3C, 24, SA, 0, 0, 6'h2A, 6'h15},
            '{8'hB8, 8'h00, 24, SA, 1, 8'h3C, 6'h2A, 6'h15}, '{8'hD9, 8'h00, 16, SA, 0, 0, 6'h2A, 6'h00},
            '{8'hE4, 8'h00, 16, SA, 0, 0, 6'h2A, 6'h00}, '{8'hA0, 8'h01, 24, SA, 0, 0, 6'h01, 6'h00},
            '{8'h14, 8'h00, 16, SA, 0, 0, 6'h2A, 6'h00}, '{8'hA1, 8'h21, 24, SA, 0, 0, 6'h2A, 6'h21},
            '{8'h8C, 8'h00, 16, SA, 0, 0, 6'h2A, 6'h21}, '{8'hA0, 8'h00, 24, SA, 0, 0, 6'h00, 6'h21},
            '{8'hBC, 8'h00, 24, SA, 1, 8'h2A, 6'h00, 6'h21}, '{8'hBD, 8'h00, 24, SA, 1, 8'h21, 6'h00, 6'h21},
            '{8'hD8, 8'h00, 24, SA, 0, 0, 6'h00, 6'h21}, '{8'hA0, 8'h3C, 24, 2'h1, 0, 0, 6'h00, 6'h21},
            '{8'hA0, 8'h3C, 24, SA, 0, 0, 6'h3C, 6'h21}, '{8'h20, 8'hFF, 24, SA, 0, 0, 6'h3F, 6'h21},
            '{8'h20, 8'h00, 24, SA, 0, 0, 6'h37, 6'h21}, '{8'h20, 8'h80, 24, SA, 0, 0, 6'h31, 6'h21},
            '{8'hA1, 8'h02, 24, SA, 0, 0, 6'h31, 6'h02}, '{8'h21, 8'h00, 24, SA, 0, 0, 6'h31, 6'h00},
            '{8'h51, 8'h00, 24, SA, 1, 8'h00, 6'h31, 6'h00}};
        miscompares = 0;
        checks = 0;
        i_sys_rst <= 1'b1;
        i_strap_addr <= SA;
        repeat (2) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        // reset values
        cmp6("wiper0 reset", 6'h00, o_wiper0);
        cmp8("flags reset", 8'h00, {5'h00, o_so_oe, o_so, o_write_in_progress});
        foreach (rows[i]) begin
            send(rows[i].ins, rows[i].dat, rows[i].n, rows[i].sa);
            settle();
            if (rows[i].ck) cmp8("read byte", rows[i].rd, rd);
            cmp6("wiper0", rows[i].w0, o_wiper0);
            cmp6("wiper1", rows[i].w1, o_wiper1);
        end
        // status read while a stored write is still running
        send(8'hC9, 8'h11, 24, SA);
        send(8'h51, 8'h00, 24, SA);
        cmp8("status busy", 8'h01, rd);
        cmp8("flag busy", 8'h01, {7'h00, o_write_in_progress});
        settle();
        cmp8("flag done", 8'h00, {7'h00, o_write_in_progress});
        send(8'hB9, 8'h00, 24, SA);
        cmp8("stored after busy", 8'h11, rd);
        // overlong write frame is dropped
        send(8'hC9, 8'h22, 25, SA);
        cmp8("flag overlong", 8'h00, {7'h00, o_write_in_progress});
        // reset in mid-run clears the wipers
        @(posedge i_ref_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        cmp6("wiper0 rerun", 6'h00, o_wiper0);
        cmp6("wiper1 rerun", 6'h00, o_wiper1);
        report_and_stop();
    end
endmodule // tb_top
